// File: design/tfc_pkg.sv
// Constants shared by the timer freeze control register bank.
package tfc_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   // Printed offsets are half-word spaced; each becomes a word index
   localparam logic [31:0] TFC_BLOCK_BASE = 32'h50003300;
   localparam logic [31:0] TFC_OFS_FREEZE_SET = 32'h50003300;
   localparam logic [31:0] TFC_OFS_FREEZE_CLEAR = 32'h50003302;
   localparam logic [31:0] TFC_OFS_DEBUG_FREEZE_CONFIG = 32'h50003304;
   localparam logic [31:0] TFC_OFS_SYSTEM_STATUS = 32'h50003306;
   localparam logic [31:0] TFC_IDX_SHIFT = 32'h00000001;
   localparam logic [1:0] TFC_IDX_FREEZE_SET = 2'((TFC_OFS_FREEZE_SET - TFC_BLOCK_BASE) >> TFC_IDX_SHIFT);
   localparam logic [1:0] TFC_IDX_FREEZE_CLEAR = 2'((TFC_OFS_FREEZE_CLEAR - TFC_BLOCK_BASE) >> TFC_IDX_SHIFT);
   localparam logic [1:0] TFC_IDX_DEBUG_CFG = 2'((TFC_OFS_DEBUG_FREEZE_CONFIG - TFC_BLOCK_BASE) >> TFC_IDX_SHIFT);
   localparam logic [1:0] TFC_IDX_SYSTEM_STATUS = 2'((TFC_OFS_SYSTEM_STATUS - TFC_BLOCK_BASE) >> TFC_IDX_SHIFT);

   // ---------------------------------------------------------------
   // Widths and field positions
   // ---------------------------------------------------------------
   localparam int unsigned TFC_DATA_W = 32;
   localparam int unsigned TFC_REG_W = 16;
   localparam int unsigned TFC_NUM_UNITS = 5;
   localparam int unsigned TFC_DMA_HALT_BIT = 4;
   localparam int unsigned TFC_WATCHDOG_HALT_BIT = 3;
   localparam int unsigned TFC_RADIO_MASTER_CLOCK_HALT_BIT = 2;
   localparam int unsigned TFC_SOFTWARE_TIMER_HALT_BIT = 1;
   localparam int unsigned TFC_WAKEUP_TIMER_HALT_BIT = 0;
   localparam int unsigned TFC_DEBUG_HALT_FREEZE_ENABLE_BIT = 0;
   localparam int unsigned TFC_CAL_PHASE_BIT = 0;
   localparam int unsigned TFC_STATUS_W = 2;

   // ---------------------------------------------------------------
   // Values after reset
   // ---------------------------------------------------------------
   localparam logic [TFC_NUM_UNITS-1:0] TFC_FREEZE_RST = 5'h00;
   localparam logic [TFC_REG_W-1:0] TFC_DEBUG_CFG_RST = 16'h0001;
   localparam logic [TFC_STATUS_W-1:0] TFC_STATUS_RST = 2'h0;

endpackage

// File: design/tfc_wb_slave.sv
// Classic Wishbone slave front end: decode, one-wait-state ack, registered read data.
`timescale 1ns/1ps
module tfc_wb_slave
   import tfc_pkg::*;
#(
   parameter int ADR_W = 4
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone request
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   // Read word from the register bank
   input wire logic [TFC_REG_W-1:0] rd_word_i,
   // Wishbone answer
   output logic wb_ack_o,
   output logic [TFC_DATA_W-1:0] wb_dat_o,
   // Decoded access toward the bank
   output logic [1:0] idx_o,
   output logic wr_commit_o
);

   logic ack_q;
   logic [TFC_DATA_W-1:0] dat_q;
   wire req = wb_cyc_i & wb_stb_i;
   wire hit = (wb_adr_i[1:0] == 2'h0) && ((wb_adr_i >> 4) == '0);

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   // Writes land on the edge where the master sees ack, not before
   assign idx_o = wb_adr_i[3:2];
   assign wr_commit_o = req & wb_we_i & ack_q & hit;
   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   // Ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_q <= 1'b0;
         dat_q <= 32'h00000000;
      end
      else
      begin
         ack_q <= req & ~ack_q;
         if (req & ~ack_q & ~wb_we_i)
            dat_q <= hit ? {16'h0000, rd_word_i} : 32'h00000000; // Unmapped reads zero
      end
   end

endmodule

// File: design/tfc_halt_gate.sv
// One unit's halt output: held freeze state combined with the debug halt.
`timescale 1ns/1ps
module tfc_halt_gate
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Freeze sources
   input wire logic held_i,
   input wire logic allow_i,
   input wire logic debug_halt_i,
   input wire logic debug_follow_i,
   // Registered halt
   output logic halt_o
);

   logic halt_q;
   logic halt_d;

   // Register the halt so the unit sees a glitch-free level
   assign halt_d = (held_i & allow_i) | (debug_halt_i & debug_follow_i);
   assign halt_o = halt_q;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         halt_q <= 1'b0;
      else
         halt_q <= halt_d;
   end

endmodule

// File: design/tfc_timer_freeze_control.sv
// Top of the timer freeze control register bank with its Wishbone slave.
//
// Behaviour
// - Set bit 4 halts DMA until cleared.
// - Set bit 3 stops the watchdog counter.
// - Watchdog freeze only with reset action selected.
// - Set bit 2 gates radio master clock.
// - Set bit 1 stops the software timer.
// - Set bit 0 stops the wake-up timer.
// - Zeros written to set change nothing.
// - Clear register ones resume matching units.
// - Zeros written to clear change nothing.
// - Debug enable freezes all timers in halt.
// - Enable off: non-watchdog halts follow held state only.
// - Watchdog always freezes during debug halt.
// - Status bit 0 read/write, reset zero.
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
module tfc_timer_freeze_control
   import tfc_pkg::*;
#(
   parameter int ADR_W = 4
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [TFC_DATA_W-1:0] wb_dat_i,
   output logic [TFC_DATA_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   // Processor and watchdog context
   input wire logic debug_halt_i,
   input wire logic wdog_nmi_sel_i,
   // Halt levels toward the units
   output logic dma_halt_o,
   output logic watchdog_halt_o,
   output logic radio_master_clock_halt_o,
   output logic software_timer_halt_o,
   output logic wakeup_timer_halt_o,
   // Status toward the system
   output logic cal_phase_o
);

   // ---------------------------------------------------------------
   // Elaboration checks
   // ---------------------------------------------------------------
   // The decode needs the word index bits 3:2 at least
   if (ADR_W < 4 || ADR_W > 32)
   begin : g_bad_adr
      $error("ADR_W must lie between 4 and 32");
   end

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [TFC_NUM_UNITS-1:0] freeze_q;
   logic [TFC_NUM_UNITS-1:0] freeze_d;
   logic [TFC_REG_W-1:0] debug_cfg_q;
   logic [TFC_REG_W-1:0] debug_cfg_d;
   logic [TFC_STATUS_W-1:0] status_q;
   logic [TFC_STATUS_W-1:0] status_d;
   logic cal_phase_q;
   logic [TFC_NUM_UNITS-1:0] halt_vec;
   logic [TFC_NUM_UNITS-1:0] allow_vec;
   logic [TFC_NUM_UNITS-1:0] follow_vec;
   logic [1:0] idx;
   logic wr_commit;
   logic [TFC_REG_W-1:0] rd_word;

   // ---------------------------------------------------------------
   // Bus front end
   // ---------------------------------------------------------------
   tfc_wb_slave #(
      .ADR_W(ADR_W)
   ) u_slave (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .rd_word_i(rd_word),
      .wb_ack_o(wb_ack_o),
      .wb_dat_o(wb_dat_o),
      .idx_o(idx),
      .wr_commit_o(wr_commit)
   );

   // ---------------------------------------------------------------
   // Write decode
   // ---------------------------------------------------------------
   // Byte lanes: sel[0] covers bits 7:0, sel[1] covers bits 15:8
   wire [TFC_REG_W-1:0] lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire [TFC_REG_W-1:0] wr_bits = wb_dat_i[TFC_REG_W-1:0] & lane_mask;
   wire wr_set = wr_commit && (idx == TFC_IDX_FREEZE_SET);
   wire wr_clear = wr_commit && (idx == TFC_IDX_FREEZE_CLEAR);
   wire wr_debug = wr_commit && (idx == TFC_IDX_DEBUG_CFG);
   wire wr_status = wr_commit && (idx == TFC_IDX_SYSTEM_STATUS);
   wire [TFC_NUM_UNITS-1:0] unit_bits = wr_bits[TFC_NUM_UNITS-1:0];
   wire debug_follow = debug_cfg_q[TFC_DEBUG_HALT_FREEZE_ENABLE_BIT];

   // ---------------------------------------------------------------
   // Freeze state vector
   // ---------------------------------------------------------------
   // Ones set or clear, zeros leave bits alone; one vector behind both
   assign freeze_d = wr_set ? (freeze_q | unit_bits) :
                     wr_clear ? (freeze_q & ~unit_bits) :
                     freeze_q;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         freeze_q <= TFC_FREEZE_RST;
      else
         freeze_q <= freeze_d;
   end

   // ---------------------------------------------------------------
   // Debug and status registers
   // ---------------------------------------------------------------
   // Unused debug bits are kept as plain storage for software
   assign debug_cfg_d = wr_debug ? ((debug_cfg_q & ~lane_mask) | wr_bits) : debug_cfg_q;
   assign status_d = wr_status ? ((status_q & ~lane_mask[TFC_STATUS_W-1:0]) | wr_bits[TFC_STATUS_W-1:0]) :
                     status_q;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         debug_cfg_q <= TFC_DEBUG_CFG_RST;
         status_q <= TFC_STATUS_RST;
         cal_phase_q <= 1'b0;
      end
      else
      begin
         debug_cfg_q <= debug_cfg_d;
         status_q <= status_d;
         cal_phase_q <= status_q[TFC_CAL_PHASE_BIT];
      end
   end

   // ---------------------------------------------------------------
   // Read mux
   // ---------------------------------------------------------------
   // Both freeze registers read back the same live vector
   wire [TFC_REG_W-1:0] freeze_word = {{(TFC_REG_W-TFC_NUM_UNITS){1'b0}}, freeze_q};
   wire [TFC_REG_W-1:0] status_word = {{(TFC_REG_W-TFC_STATUS_W){1'b0}}, status_q};
   assign rd_word = (idx == TFC_IDX_FREEZE_SET) ? freeze_word :
                    (idx == TFC_IDX_FREEZE_CLEAR) ? freeze_word :
                    (idx == TFC_IDX_DEBUG_CFG) ? debug_cfg_q :
                    status_word;

   // ---------------------------------------------------------------
   // Per-unit halt gating
   // ---------------------------------------------------------------
   // Watchdog is special: held freeze needs reset action, debug always wins
   genvar u;
   for (u = 0; u < TFC_NUM_UNITS; u++)
   begin : g_unit
      if (u == TFC_WATCHDOG_HALT_BIT)
      begin : g_wdog
         assign allow_vec[u] = ~wdog_nmi_sel_i;
         assign follow_vec[u] = 1'b1;
      end
      else
      begin : g_other
         assign allow_vec[u] = 1'b1;
         assign follow_vec[u] = debug_follow;
      end
      tfc_halt_gate u_gate (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .held_i(freeze_q[u]),
         .allow_i(allow_vec[u]),
         .debug_halt_i(debug_halt_i),
         .debug_follow_i(follow_vec[u]),
         .halt_o(halt_vec[u])
      );
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign dma_halt_o = halt_vec[TFC_DMA_HALT_BIT];
   assign watchdog_halt_o = halt_vec[TFC_WATCHDOG_HALT_BIT];
   assign radio_master_clock_halt_o = halt_vec[TFC_RADIO_MASTER_CLOCK_HALT_BIT];
   assign software_timer_halt_o = halt_vec[TFC_SOFTWARE_TIMER_HALT_BIT];
   assign wakeup_timer_halt_o = halt_vec[TFC_WAKEUP_TIMER_HALT_BIT];
   assign cal_phase_o = cal_phase_q;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb_main @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // Set of DMA bit is held after one edge and reaches the output one edge later
   chk_dma_set_halts: assert property (wr_set && unit_bits[TFC_DMA_HALT_BIT] |=> freeze_q[TFC_DMA_HALT_BIT] ##1 dma_halt_o)
      else $error("DMA not halted after freeze set");

   // Held watchdog freeze with reset action stops the watchdog
   chk_wdog_held: assert property ($past(freeze_q[TFC_WATCHDOG_HALT_BIT]) && !$past(wdog_nmi_sel_i) |-> watchdog_halt_o)
      else $error("watchdog not halted while frozen");

   // Interrupt action keeps the watchdog running outside debug
   chk_wdog_nmi_runs: assert property (!$past(debug_halt_i) && $past(wdog_nmi_sel_i) |-> !watchdog_halt_o)
      else $error("watchdog halted in interrupt mode");

   // Radio master clock gated two edges after set
   chk_radio_set: assert property (wr_set && unit_bits[TFC_RADIO_MASTER_CLOCK_HALT_BIT] |-> ##2 radio_master_clock_halt_o)
      else $error("radio clock not gated after freeze set");

   // Software timer stopped two edges after set
   chk_swtim_set: assert property (wr_set && unit_bits[TFC_SOFTWARE_TIMER_HALT_BIT] |-> ##2 software_timer_halt_o)
      else $error("software timer not halted after freeze set");

   // Wake-up timer stopped two edges after set
   chk_wkup_set: assert property (wr_set && unit_bits[TFC_WAKEUP_TIMER_HALT_BIT] |-> ##2 wakeup_timer_halt_o)
      else $error("wake-up timer not halted after freeze set");

   // A set write only ever adds bits
   chk_set_zeros: assert property (wr_set |=> freeze_q == ($past(freeze_q) | $past(unit_bits)))
      else $error("freeze set changed bits written as zero");

   // Clear ones drop the matching bits
   chk_clear_ones: assert property (wr_clear |=> (freeze_q & $past(unit_bits)) == 5'h00)
      else $error("freeze clear left a unit frozen");

   // Clear zeros keep the other bits
   chk_clear_zeros: assert property (wr_clear |=> (freeze_q & ~$past(unit_bits)) == ($past(freeze_q) & ~$past(unit_bits)))
      else $error("freeze clear touched bits written as zero");

   // Debug halt with enable set halts every unit
   chk_dbg_all: assert property ($past(debug_halt_i) && $past(debug_follow) |-> halt_vec == 5'h1f)
      else $error("debug halt did not freeze all timers");

   // Enable off: non-watchdog halts mirror the held state
   chk_dbg_follow: assert property (!$past(debug_follow) |-> (halt_vec & 5'h17) == ($past(freeze_q) & 5'h17))
      else $error("non-watchdog halt not following held state");

   // Watchdog always frozen in debug halt
   chk_wdog_debug: assert property ($past(debug_halt_i) |-> watchdog_halt_o)
      else $error("watchdog running during debug halt");

   // Status bit 0 written reaches the output two edges later
   chk_cal_phase: assert property (wr_status && wb_sel_i[0] |-> ##2 cal_phase_o == $past(wb_dat_i[TFC_CAL_PHASE_BIT], 2))
      else $error("calibration phase bit not stored");

   // Reads of either freeze register return the vector
   chk_read_vector: assert property (wb_ack_o && !wb_we_i && wb_adr_i[1:0] == 2'h0 && (wb_adr_i >> 4) == '0 &&
                                     (idx == TFC_IDX_FREEZE_SET || idx == TFC_IDX_FREEZE_CLEAR)
                                     |-> wb_dat_o == {27'h0000000, freeze_q})
      else $error("freeze register read mismatch");

   // ---------------------------------------------------------------
   // Bus protocol and storage checks
   // ---------------------------------------------------------------
   // Ack is a single-cycle pulse so the master never sees a double answer
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held for more than one cycle");

   // A fresh request is answered exactly one cycle later
   chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing one cycle after request");

   // No ack without a request in the cycle before
   chk_ack_no_req: assert property (!$past(wb_cyc_i && wb_stb_i) |-> !wb_ack_o)
      else $error("ack without a request");

   // Misaligned writes must never reach a register
   chk_unmapped_write: assert property (wb_ack_o && wb_we_i && wb_adr_i[1:0] != 2'h0 |-> !wr_commit)
      else $error("unmapped write committed");

   // Freeze vector moves only through a set or clear commit
   chk_vector_quiet: assert property (!wr_set && !wr_clear |=> $stable(freeze_q))
      else $error("freeze vector changed without a write");

   // Debug configuration holds between its own writes
   chk_cfg_quiet: assert property (!wr_debug |=> $stable(debug_cfg_q))
      else $error("debug configuration changed without a write");

   // Status register holds between its own writes
   chk_status_quiet: assert property (!wr_status |=> $stable(status_q))
      else $error("status changed without a write");

   // Calibration output trails the status bit by one edge
   chk_cal_follow: assert property (1'b1 |=> cal_phase_o == $past(status_q[TFC_CAL_PHASE_BIT]))
      else $error("calibration output not following status");

   // Upper half of every answer is zero, registers are 16 bits
   chk_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
      else $error("read data upper half not zero");

   // Main scenarios
   cov_dma_freeze_release: cover property (wr_set && unit_bits[TFC_DMA_HALT_BIT] ##[2:50] wr_clear && unit_bits[TFC_DMA_HALT_BIT]);
   cov_debug_follow_all: cover property (debug_halt_i && debug_follow ##1 halt_vec == 5'h1f);
   cov_debug_no_follow: cover property (debug_halt_i && !debug_follow && freeze_q != 5'h00);
   cov_wdog_nmi_freeze: cover property (freeze_q[TFC_WATCHDOG_HALT_BIT] && wdog_nmi_sel_i && !debug_halt_i);
   cov_status_write: cover property (wr_status && wb_sel_i[0] && wb_dat_i[TFC_CAL_PHASE_BIT]);

endmodule

// File: verification/tfc_unit_model.sv
// Behavioural far side: debug-halt source, watchdog mode and unit tick counters.
`timescale 1ns/1ps
module tfc_unit_model
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bench commands
   input wire logic debug_req_i,
   input wire logic nmi_req_i,
   // Halt levels from the bank, bit 4 DMA down to bit 0 wake-up
   input wire logic [4:0] halt_i,
   // Context toward the bank
   output logic debug_halt_o,
   output logic wdog_nmi_sel_o,
   // Tick counters of the five units, eight bits each
   output logic [39:0] ticks_o
);
   // Context changes just after an edge, as a halting core would
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         debug_halt_o <= 1'b0;
         wdog_nmi_sel_o <= 1'b0;
      end
      else
      begin
         debug_halt_o <= debug_req_i;
         wdog_nmi_sel_o <= nmi_req_i;
      end
   end

   // Each unit advances one tick per cycle unless held; wraps freely
   always_ff @(posedge clk_i)
   begin
      for (int k = 0; k < 5; k++)
      begin
         if (rst_i)
            ticks_o[8*k +: 8] <= 8'h00;
         else if (!halt_i[k])
            ticks_o[8*k +: 8] <= ticks_o[8*k +: 8] + 8'h01;
      end
   end
endmodule

// File: verification/tfc_timer_freeze_control_bench.sv
// Self-checking random bench for the timer freeze control register bank.
`timescale 1ns/1ps
module tfc_timer_freeze_control_bench import tfc_pkg::*;;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [3:0] wb_adr_i = 4'h0;
   logic [3:0] wb_sel_i = 4'h0;
   logic [TFC_DATA_W-1:0] wb_dat_i = 32'h0;
   logic [TFC_DATA_W-1:0] wb_dat_o;
   logic wb_ack_o;
   logic dbg_req = 1'b0;
   logic nmi_req = 1'b0;
   logic debug_halt_i;
   logic wdog_nmi_sel_i;
   logic [4:0] halts;
   logic cal_phase_o;
   logic [39:0] ticks;
   logic [39:0] tsnap;
   logic [4:0] vec_m;
   logic [15:0] cfg_m;
   logic [1:0] st_m;
   logic [31:0] rd;
   logic [31:0] op;
   logic [15:0] d;
   int n_fail = 0;
   int check_count = 0;
   int cyc_count = 0;
   integer seed = 32'hd54ec7ae;

   always #12.5 clk_i = ~clk_i;

   tfc_timer_freeze_control uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .debug_halt_i(debug_halt_i), .wdog_nmi_sel_i(wdog_nmi_sel_i),
      .dma_halt_o(halts[4]), .watchdog_halt_o(halts[3]), .radio_master_clock_halt_o(halts[2]),
      .software_timer_halt_o(halts[1]), .wakeup_timer_halt_o(halts[0]), .cal_phase_o(cal_phase_o));

   tfc_unit_model far_side (.clk_i(clk_i), .rst_i(rst_i), .debug_req_i(dbg_req), .nmi_req_i(nmi_req),
      .halt_i(halts), .debug_halt_o(debug_halt_i), .wdog_nmi_sel_o(wdog_nmi_sel_i), .ticks_o(ticks));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic end_sim();
      if (n_fail == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         $display("Error %s expected %h seen %h", what, exp, got);
         n_fail++;
      end
   endtask

   // Classic single cycle; request held until the edge where ack is seen
   task automatic wb_cycle(input logic w, input logic [3:0] a, input logic [15:0] dd, input logic [3:0] s,
                           output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= {16'($random(seed)), dd};
      // Ack and read data are taken at the rising edge where ack is high
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && n < 20)
      begin
         n++;
         @(posedge clk_i);
      end
      if (n == 20)
         n_fail++;
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   // Watchdog ignores the enable; others obey it during a debug halt
   function automatic logic [4:0] halt_exp();
      logic [4:0] e;
      e = vec_m | {5{dbg_req & cfg_m[0]}};
      e[3] = (vec_m[3] & ~nmi_req) | dbg_req;
      return e;
   endfunction

   function automatic logic [31:0] reg_exp(input logic [3:0] a);
      case (a)
         4'h0, 4'h4: return {27'h0, vec_m};
         4'h8: return {16'h0, cfg_m};
         4'hc: return {30'h0, st_m};
         default: return 32'h0;
      endcase
   endfunction

   // Hang guard, well above the expected run length
   always @(posedge clk_i)
   begin
      cyc_count++;
      if (cyc_count == 20000)
      begin
         n_fail++;
         end_sim();
      end
   end

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      vec_m = 5'h00;
      cfg_m = 16'h0001;
      st_m = 2'h0;
      // Reset values of all four registers
      for (int a = 0; a < 16; a += 4)
      begin
         wb_cycle(1'b0, 4'(a), 16'h0, 4'hf, rd);
         check("reset value", reg_exp(4'(a)), rd);
      end
      // Misaligned address: write ignored, read zero
      wb_cycle(1'b1, 4'h2, 16'h001f, 4'hf, rd);
      wb_cycle(1'b0, 4'h2, 16'h0, 4'hf, rd);
      check("unmapped read", 32'h0, rd);
      // Lane 0 off leaves the freeze vector alone
      wb_cycle(1'b1, 4'h0, 16'h001f, 4'he, rd);
      wb_cycle(1'b0, 4'h0, 16'h0, 4'hf, rd);
      check("set lane0 off", 32'h0, rd);
      // Random mix of set, clear, config, status and halt context
      for (int i = 0; i < 150; i++)
      begin
         op = $random(seed);
         d = 16'($random(seed));
         if (i < 6)
            d = 16'h001f >> (i % 5);
         dbg_req <= op[2];
         nmi_req <= op[3];
         wb_cycle(1'b1, {op[1:0], 2'b00}, d, op[7:4], rd);
         if (op[4])
         begin
            case (op[1:0])
               2'd0: vec_m = vec_m | d[4:0];
               2'd1: vec_m = vec_m & ~d[4:0];
               2'd2: cfg_m[7:0] = d[7:0];
               default: st_m = d[1:0];
            endcase
         end
         if (op[5] && op[1:0] == 2'd2)
            cfg_m[15:8] = d[15:8];
         repeat (3) @(posedge clk_i);
         check("halts", {27'h0, halt_exp()}, {27'h0, halts});
         check("cal phase", {31'h0, st_m[0]}, {31'h0, cal_phase_o});
         tsnap = ticks;
         repeat (4) @(posedge clk_i);
         for (int k = 0; k < 5; k++)
            check("ticks", {24'h0, tsnap[8*k +: 8] + (halt_exp()[k] ? 8'h0 : 8'h4)}, {24'h0, ticks[8*k +: 8]});
         wb_cycle(1'b0, {op[9:8], 2'b00}, 16'h0, 4'hf, rd);
         check("readback", reg_exp({op[9:8], 2'b00}), rd);
      end
      end_sim();
   end
endmodule
